// ---- logic/rail_enable_override_regs.v ----
// How it works
// - disable bit 7 forces shared rail off
// - factory setting picks which rail shares bits
// - disable bit 6 forces switch B first off
// - disable bit 5 forces switch A off
// - disable bit 4 forces termination regulator off
// - force-on clear: pin or power-good decides
// - override bit 7 forces linear regulator two
// - override bit 6 forces switch A on
// - override bit 5 forces step-down six on
// - override bit 4 forces step-down five on
// - override bit 3 forces step-down four on
// - override bit 2 forces step-down three on
// - override bit 1 forces step-down two on
// - override bit 0 forces step-down one on
// - separate register holds step-down one-three disables
`timescale 1ns/1ns
`default_nettype none
`include "rail_regs_map.vh"
module rail_enable_override_regs #(
  parameter [6:0] DEV_ADDR = 7'h5E, // arbitrary target address
  parameter [7:0] DISABLE_RESET = `RST_RAIL_DISABLE,
  parameter [7:0] FORCE_RESET = `RST_RAIL_FORCE_ON,
  parameter [7:0] STEPDOWN_CTRL_RESET = `RST_STEPDOWN_CTRL
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // two-wire serial interface
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // factory setting: 1 shares bits with linear regulator one
  input wire otp_shared_is_linreg,
  // per-rail pin or power-good requests
  input wire [`RAIL_COUNT-1:0] rail_control_inputs,
  // disable bits of step-down four to six and linear regulator two
  input wire [3:0] ext_off_n,
  // force-on bits of switch B first, shared rail, termination
  input wire [2:0] ext_force_on,
  // final rail enables
  output reg [`RAIL_COUNT-1:0] rail_enable
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_PTR = 3'h2;
  localparam [2:0] ST_WR = 3'h3;
  localparam [2:0] ST_ACK = 3'h4;
  localparam [2:0] ST_RD = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  reg [7:0] rail_disable_group_b_r;
  reg [7:0] rail_force_on_group_a_r;
  reg [7:0] stepdown_ctrl_r;
  reg [2:0] state_r;
  reg [2:0] ret_r;
  reg [3:0] cnt_r;
  reg [7:0] sr_r;
  reg [7:0] tx_r;
  reg [7:0] ptr_r;
  reg scl_d_r;
  reg sda_d_r;
  reg host_ack_r;
  reg [7:0] rd_data;
  reg [`RAIL_COUNT-1:0] off_n;
  reg [`RAIL_COUNT-1:0] force_on;
  wire start_c;
  wire stop_c;
  wire scl_rise;
  wire scl_fall;

  // bus conditions from previous samples
  assign start_c = scl & scl_d_r & sda_d_r & ~sda_in;
  assign stop_c = scl & scl_d_r & ~sda_d_r & sda_in;
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;

  // open-drain data: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = (state_r == ST_ACK) | ((state_r == ST_RD) & ~tx_r[`BYTE_MSB]);

  // read mux, unmapped offsets read zero
  always @* begin
    case (ptr_r)
      `OFS_STEPDOWN_CTRL: rd_data = stepdown_ctrl_r;
      `OFS_RAIL_DISABLE: rd_data = rail_disable_group_b_r;
      `OFS_RAIL_FORCE_ON: rd_data = rail_force_on_group_a_r;
      default: rd_data = 8'h00;
    endcase
  end

  // per-rail disable and force-on gathering
  always @* begin
    off_n = {`RAIL_COUNT{1'b1}};
    force_on = {`RAIL_COUNT{1'b0}};
    off_n[`RAIL_STEPDOWN_ONE] = stepdown_ctrl_r[`BIT_STEPDOWN_ONE_OFF_N];
    off_n[`RAIL_STEPDOWN_TWO] = stepdown_ctrl_r[`BIT_STEPDOWN_TWO_OFF_N];
    off_n[`RAIL_STEPDOWN_THREE] = stepdown_ctrl_r[`BIT_STEPDOWN_THREE_OFF_N];
    off_n[`RAIL_STEPDOWN_FOUR] = ext_off_n[0];
    off_n[`RAIL_STEPDOWN_FIVE] = ext_off_n[1];
    off_n[`RAIL_STEPDOWN_SIX] = ext_off_n[2];
    off_n[`RAIL_LINREG_SECOND] = ext_off_n[3];
    off_n[`RAIL_SWITCH_B_FIRST] = rail_disable_group_b_r[`BIT_SWITCH_B_FIRST_OFF_N];
    off_n[`RAIL_SWITCH_A] = rail_disable_group_b_r[`BIT_SWITCH_A_OFF_N];
    off_n[`RAIL_TERMINATION] = rail_disable_group_b_r[`BIT_TERMINATION_OFF_N];
    // shared bits steer one of two rails
    if (otp_shared_is_linreg) begin
      off_n[`RAIL_LINREG_FIRST] = rail_disable_group_b_r[`BIT_SHARED_OFF_N];
      force_on[`RAIL_LINREG_FIRST] = ext_force_on[1];
    end else begin
      off_n[`RAIL_SWITCH_B_SECOND] = rail_disable_group_b_r[`BIT_SHARED_OFF_N];
      force_on[`RAIL_SWITCH_B_SECOND] = ext_force_on[1];
    end
    force_on[`RAIL_STEPDOWN_ONE] = rail_force_on_group_a_r[`BIT_STEPDOWN_ONE_ON];
    force_on[`RAIL_STEPDOWN_TWO] = rail_force_on_group_a_r[`BIT_STEPDOWN_TWO_ON];
    force_on[`RAIL_STEPDOWN_THREE] = rail_force_on_group_a_r[`BIT_STEPDOWN_THREE_ON];
    force_on[`RAIL_STEPDOWN_FOUR] = rail_force_on_group_a_r[`BIT_STEPDOWN_FOUR_ON];
    force_on[`RAIL_STEPDOWN_FIVE] = rail_force_on_group_a_r[`BIT_STEPDOWN_FIVE_ON];
    force_on[`RAIL_STEPDOWN_SIX] = rail_force_on_group_a_r[`BIT_STEPDOWN_SIX_ON];
    force_on[`RAIL_SWITCH_A] = rail_force_on_group_a_r[`BIT_SWITCH_A_ON];
    force_on[`RAIL_LINREG_SECOND] = rail_force_on_group_a_r[`BIT_LINREG_SECOND_ON];
    force_on[`RAIL_SWITCH_B_FIRST] = ext_force_on[0];
    force_on[`RAIL_TERMINATION] = ext_force_on[2];
  end

  // registered final enables
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rail_enable <= {`RAIL_COUNT{1'b0}};
    end else begin
      rail_enable <= off_n & (force_on | rail_control_inputs);
    end
  end

  // serial target and register file
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rail_disable_group_b_r <= DISABLE_RESET;
      rail_force_on_group_a_r <= FORCE_RESET;
      stepdown_ctrl_r <= STEPDOWN_CTRL_RESET;
      state_r <= ST_IDLE;
      ret_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      tx_r <= 8'hFF;
      ptr_r <= 8'h00;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      host_ack_r <= 1'b0;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda_in;
      if (start_c) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
      end else begin
        case (state_r)
          ST_ADDR, ST_PTR, ST_WR: begin
            if (scl_rise) begin
              sr_r <= {sr_r[6:0], sda_in};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `BITS_PER_BYTE) begin
              cnt_r <= 4'h0;
              state_r <= ST_ACK;
              if (state_r == ST_ADDR) begin
                if (sr_r[`ADDR_HI:`ADDR_LO] != DEV_ADDR) begin
                  state_r <= ST_IDLE;
                end
                ret_r <= sr_r[`RW_BIT] ? ST_RD : ST_PTR;
              end else if (state_r == ST_PTR) begin
                ptr_r <= sr_r;
                ret_r <= ST_WR;
              end else begin
                // reserved low bits stored as written
                case (ptr_r)
                  `OFS_STEPDOWN_CTRL: stepdown_ctrl_r <= sr_r & `STEPDOWN_CTRL_WMASK;
                  `OFS_RAIL_DISABLE: rail_disable_group_b_r <= sr_r;
                  `OFS_RAIL_FORCE_ON: rail_force_on_group_a_r <= sr_r;
                  default: ;
                endcase
                ptr_r <= ptr_r + 8'h01;
                ret_r <= ST_WR;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state_r <= ret_r;
              if (ret_r == ST_RD) begin
                tx_r <= rd_data;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (cnt_r == `LAST_TX_BIT) begin
                cnt_r <= 4'h0;
                tx_r <= 8'hFF;
                state_r <= ST_RACK;
              end else begin
                cnt_r <= cnt_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b1};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              host_ack_r <= ~sda_in;
            end else if (scl_fall) begin
              if (host_ack_r) begin
                state_r <= ST_RD;
                tx_r <= rd_data;
                ptr_r <= ptr_r + 8'h01;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // rail_enable_override_regs
`default_nettype wire

// ---- shared/rail_regs_map.vh ----
`ifndef RAIL_REGS_MAP_VH
`define RAIL_REGS_MAP_VH
// register offsets on the serial interface
`define OFS_STEPDOWN_CTRL 8'h9C
`define OFS_RAIL_DISABLE 8'h9F
`define OFS_RAIL_FORCE_ON 8'hA0
// reset values (factory programmed, default here)
`define RST_STEPDOWN_CTRL 8'h00
`define RST_RAIL_DISABLE 8'h00
`define RST_RAIL_FORCE_ON 8'h00
// writable bits of the step-down control register
`define STEPDOWN_CTRL_WMASK 8'h3F
// rail disable register bits
`define BIT_SHARED_OFF_N 7
`define BIT_SWITCH_B_FIRST_OFF_N 6
`define BIT_SWITCH_A_OFF_N 5
`define BIT_TERMINATION_OFF_N 4
// override register force-on bits
`define BIT_STEPDOWN_ONE_ON 0
`define BIT_STEPDOWN_TWO_ON 1
`define BIT_STEPDOWN_THREE_ON 2
`define BIT_STEPDOWN_FOUR_ON 3
`define BIT_STEPDOWN_FIVE_ON 4
`define BIT_STEPDOWN_SIX_ON 5
`define BIT_SWITCH_A_ON 6
`define BIT_LINREG_SECOND_ON 7
// step-down control register disable bits
`define BIT_STEPDOWN_THREE_OFF_N 2
`define BIT_STEPDOWN_TWO_OFF_N 1
`define BIT_STEPDOWN_ONE_OFF_N 0
// rail indices in the enable vectors
`define RAIL_STEPDOWN_ONE 0
`define RAIL_STEPDOWN_TWO 1
`define RAIL_STEPDOWN_THREE 2
`define RAIL_STEPDOWN_FOUR 3
`define RAIL_STEPDOWN_FIVE 4
`define RAIL_STEPDOWN_SIX 5
`define RAIL_SWITCH_A 6
`define RAIL_LINREG_SECOND 7
`define RAIL_SWITCH_B_FIRST 8
`define RAIL_SWITCH_B_SECOND 9
`define RAIL_LINREG_FIRST 10
`define RAIL_TERMINATION 11
`define RAIL_COUNT 12
// serial interface byte handling
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7
`define BYTE_MSB 7
`define ADDR_HI 7
`define ADDR_LO 1
`define RW_BIT 0
`endif

// ---- verif/rail_enable_override_regs_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module rail_enable_override_regs_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // rail side
  input wire otp_shared_is_linreg,
  input wire [11:0] rail_control_inputs,
  input wire [3:0] ext_off_n,
  input wire [2:0] ext_force_on,
  input wire [11:0] rail_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // outside disables beat any request
  chk_four_off: assert property (!ext_off_n[0] |=> !rail_enable[3])
    else $error("four on while off");
  chk_five_off: assert property (!ext_off_n[1] |=> !rail_enable[4])
    else $error("five on while off");
  chk_six_off: assert property (rail_enable[5] |-> $past(ext_off_n[2]))
    else $error("six on while off");
  chk_linreg_off: assert property (rail_enable[7] |-> $past(ext_off_n[3]))
    else $error("linreg two on while off");
  // a pin request passes when not disabled, and switch B first needs force or request
  chk_four_pin: assert property (ext_off_n[0] && rail_control_inputs[3] |=> rail_enable[3])
    else $error("four ignores request");
  chk_swb_cause: assert property (rail_enable[8] |->
    $past(ext_force_on[0] | rail_control_inputs[8])) else $error("switch on without cause");
  // the rail not picked by the factory bit follows its request only
  chk_unsel_b: assert property (!$past(rst) && $past(otp_shared_is_linreg) |->
    rail_enable[9] == $past(rail_control_inputs[9])) else $error("unpicked switch wrong");
  chk_unsel_lin: assert property (!$past(rst) && !$past(otp_shared_is_linreg) |->
    rail_enable[10] == $past(rail_control_inputs[10])) else $error("unpicked linreg wrong");
endmodule // rail_enable_override_regs_checker
bind rail_enable_override_regs rail_enable_override_regs_checker u_chk (.clk(clk), .rst(rst),
  .otp_shared_is_linreg(otp_shared_is_linreg), .rail_control_inputs(rail_control_inputs),
  .ext_off_n(ext_off_n), .ext_force_on(ext_force_on), .rail_enable(rail_enable));
`default_nettype wire

// ---- verif/rail_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rail_host_model (
  // clock
  input wire logic clk,
  // bus pins
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output wire logic sda_in
);
  logic hd = 1'b1;
  // acknowledge bits seen low since start of run
  logic [7:0] acks = 8'h00;
  initial scl = 1'b1;
  // pulled-up open drain: released line reads high, driven line shows the pin level
  assign sda_in = hd & (~sda_oe | sda_out);
  // data moves with scl low, sampled at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    hd = b;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    r = sda_in;
    scl = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    hd = 1'b1;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    hd = 1'b0;
    repeat (2) @(negedge clk);
    scl = 1'b0;
  endtask
  task automatic stop();
    hd = 1'b0;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    hd = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(last, a);
    if (a === 1'b0) acks = acks + 8'h01;
  endtask
endmodule // rail_host_model
`default_nettype wire

// ---- verif/rail_enable_override_regs_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module rail_enable_override_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic otp = 1'b0;
  logic [11:0] req = 12'h000;
  logic [3:0] eoff = 4'h0;
  logic [2:0] ef = 3'h0;
  logic [7:0] dis = 8'h00, frc = 8'h00, ctl = 8'h00, q;
  logic [31:0] seed = 32'hEB9C;
  wire scl, sda_in, sda_out, sda_oe;
  wire [11:0] en;
  int mismatches = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  rail_host_model host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl),
    .sda_in(sda_in));
  rail_enable_override_regs #(.DEV_ADDR(7'h5E)) DUT (.clk(clk), .rst(rst), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .otp_shared_is_linreg(otp),
    .rail_control_inputs(req), .ext_off_n(eoff), .ext_force_on(ef), .rail_enable(en));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected enables: disable AND (force OR request)
  function automatic logic [11:0] exp_en();
    logic [11:0] off;
    off = {dis[4], otp ? dis[7] : 1'b1, otp ? 1'b1 : dis[7], dis[6], eoff[3], dis[5],
      eoff[2:0], ctl[2:0]};
    return off & ({ef[2], otp & ef[1], ~otp & ef[1], ef[0], frc} | req);
  endfunction
  // rail enable vector compare
  task automatic chk_en(input string nm, input logic [11:0] e, input logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // register read data compare
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // acknowledge count compare
  task automatic chk_ack(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // write two bytes from pointer p to target byte ad; only our address is acked
  task automatic wr(input logic [7:0] ad, input logic [7:0] p, input logic [7:0] a,
    input logic [7:0] b);
    logic [7:0] n;
    n = host.acks;
    host.start();
    host.xfer(ad, 1'b1, q);
    host.xfer(p, 1'b1, q);
    host.xfer(a, 1'b1, q);
    host.xfer(b, 1'b1, q);
    host.stop();
    chk_ack("write acks", (ad == 8'hBC) ? 8'h04 : 8'h00, host.acks - n);
  endtask
  // two-byte read, host acks the first byte
  task automatic rd2(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] d0, d1;
    host.start();
    host.xfer(8'hBC, 1'b1, q);
    host.xfer(p, 1'b1, q);
    host.start();
    host.xfer(8'hBD, 1'b1, q);
    host.xfer(8'hFF, 1'b0, d0);
    host.xfer(8'hFF, 1'b1, d1);
    host.stop();
    chk_reg("burst first", e0, d0);
    chk_reg("burst second", e1, d1);
  endtask
  // pointer write, repeated start, one byte read with nack
  task automatic rd(input string nm, input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    host.start();
    host.xfer(8'hBC, 1'b1, q);
    host.xfer(p, 1'b1, q);
    host.start();
    host.xfer(8'hBD, 1'b1, q);
    host.xfer(8'hFF, 1'b1, d);
    host.stop();
    chk_reg(nm, e, d);
  endtask
  initial begin
    repeat (40000) @(negedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    // wrong target address is refused and leaves the registers alone
    wr(8'hBE, 8'h9F, 8'hAA, 8'hAA);
    rd("disable reset", 8'h9F, 8'h00);
    rd("force reset", 8'hA0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      dis = (i == 0) ? 8'hF0 : (i == 1) ? 8'h00 : (8'(rnd()) & 8'hF0);
      frc = (i == 1) ? 8'hFF : 8'(rnd());
      ctl = (i == 0) ? 8'hFF : 8'(rnd());
      wr(8'hBC, 8'h9F, dis, frc);
      wr(8'hBC, 8'h9C, ctl, 8'h55);
      rd2(8'h9F, dis, frc);
      rd("disable reg", 8'h9F, dis);
      rd("force reg", 8'hA0, frc);
      rd("stepdown reg", 8'h9C, ctl & 8'h3F);
      rd("unmapped", 8'h9E, 8'h00);
      for (int j = 0; j < 16; j++) begin
        {otp, ef, eoff, req} = 20'(rnd());
        repeat (2) @(negedge clk);
        chk_en("rails", exp_en(), en);
      end
    end
    // reset in mid-run returns registers and enables to reset state
    rst = 1'b1;
    dis = 8'h00;
    frc = 8'h00;
    ctl = 8'h00;
    repeat (2) @(negedge clk);
    chk_en("enables in reset", 12'h000, en);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_en("enables after reset", exp_en(), en);
    rd("disable rereset", 8'h9F, 8'h00);
    rd("stepdown rereset", 8'h9C, 8'h00);
    finish_test();
  end
endmodule // rail_enable_override_regs_tb_top
`default_nettype wire
